// ---- verilog/mses_top.sv ----
// event selection and qualification for mesh stop performance counting
//
// Functional notes
// - Code e1 counts each ingress allocation of a class enabled in the unit mask.
// - The ingress queue holds mesh requests until forwarded; its entries feed these events.
// - Code e0 adds, every cycle, the ingress occupancy of each enabled class.
// - Code e2 counts each packet of an enabled class that bypasses the ingress.
// - An ingress class enters starvation mode after a prolonged inability to inject.
// - Code e5 counts starvation cycles lost to the competing queue, for enabled addr and data classes only.
// - Codes e3 and e4 count starvation cycles for lack of egress credit; e4 is ack-credit only.
// - Setting credited and uncredited bits of one class counts the sum of both for e0, e1 and e2, and one per cycle for e3 and e5.
// - Codes d0, d2, d4 count addr agent0, addr agent1, data agent0 transgress credit stalls.
// - For those stall events mask bit n enables transgress index n, n from 0 to 7.
// - Code ad counts horizontal sink starvation per ring class, bit 5 is ack to agent 1.
// - Code ab counts vertical sink starvation per ring class, bit 4 is the ack credit class.
`default_nettype none
module mses_top
  import mses_pkg::*;
#(
  parameter int unsigned OCC_W      = 6,
  parameter int unsigned STARVE_CYC = MSES_STARVE_CYC,
  parameter int unsigned INC_W      = OCC_W + 3
)(
  input  wire logic                        CLK_I,
  input  wire logic                        ARST_N_I,
  // counter control from software
  input  wire logic [MSES_CODE_W-1:0]      EVT_CODE_I,
  input  wire logic [MSES_UMASK_W-1:0]     UMASK_I,
  input  wire logic                        COUNT_EN_I,
  // ingress datapath conditions, one bit per class; occupancy OCC_W bits per class
  input  wire logic [MSES_CLS_N-1:0]       ING_ALLOC_I,
  input  wire logic [MSES_CLS_N-1:0]       ING_BYPASS_I,
  input  wire logic [MSES_CLS_N*OCC_W-1:0] ING_OCC_I,
  input  wire logic [MSES_CLS_N-1:0]       ING_BLOCKED_I,
  input  wire logic [MSES_CLS_N-1:0]       ING_PRIO_LOSS_I,
  input  wire logic [MSES_CLS_N-1:0]       ING_NO_CRD_I,
  // ring sink starvation conditions
  input  wire logic [MSES_CLS_N-1:0]       HSINK_STARVE_I,
  input  wire logic [MSES_CLS_N-1:0]       VSINK_STARVE_I,
  // egress stalls per transgress index
  input  wire logic [MSES_CLS_N-1:0]       ADDR_AG0_STALL_I,
  input  wire logic [MSES_CLS_N-1:0]       ADDR_AG1_STALL_I,
  input  wire logic [MSES_CLS_N-1:0]       DATA_AG0_STALL_I,
  // counter increment and status
  output logic      [INC_W-1:0]            INC_O,
  output logic                             EVT_HIT_O,
  output logic                             CODE_OK_O,
  output logic      [MSES_CLS_N-1:0]       STARVE_MODE_O
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  // decode and selection
  mses_kind_t                  kind;
  logic [MSES_CLS_N-1:0]       valid_msk;
  logic [MSES_CLS_N-1:0]       cond_vec;
  logic [MSES_CLS_N-1:0]       ing_en;
  logic [MSES_CLS_N-1:0]       hit_vec;

  // starvation mode and its causes
  logic [MSES_CLS_N-1:0]       starve;
  logic [MSES_CLS_N-1:0]       prio_stv;
  logic [MSES_CLS_N-1:0]       crd_stv;

  // increment amount
  logic [INC_W-1:0]            occ_sum;
  logic [INC_W-1:0]            cnt_chain [MSES_CLS_N+1];
  logic [INC_W-1:0]            hit_cnt;
  logic [INC_W-1:0]            inc_sel;
  logic                        any_hit;
  logic                        is_occ;
  logic                        is_sum;

  // output registers and their next values
  logic [INC_W-1:0]            inc_r;
  logic [INC_W-1:0]            inc_nxt;
  logic                        hit_r;
  logic                        hit_nxt;
  logic                        ok_r;
  logic                        ok_nxt;
  logic [MSES_CLS_N-1:0]       stv_out_r;
  logic [MSES_CLS_N-1:0]       stv_out_nxt;

  // ---------------------------------------------------------------
  // event code decode
  // ---------------------------------------------------------------
  // map the programmed code onto an event kind
  always_comb
  begin
    case (EVT_CODE_I)
      MSES_EVT_OCC:        kind = MSES_K_OCC;
      MSES_EVT_ALLOC:      kind = MSES_K_ALLOC;
      MSES_EVT_BYPASS:     kind = MSES_K_BYPASS;
      MSES_EVT_CRD_STARVE: kind = MSES_K_CRD_STV;
      MSES_EVT_CRD_EXT:    kind = MSES_K_CRD_EXT;
      MSES_EVT_PRIO_STV:   kind = MSES_K_PRIO_STV;
      MSES_EVT_HSINK:      kind = MSES_K_HSINK;
      MSES_EVT_VSINK:      kind = MSES_K_VSINK;
      MSES_EVT_ADDR_AG0:   kind = MSES_K_ADDR_AG0;
      MSES_EVT_ADDR_AG1:   kind = MSES_K_ADDR_AG1;
      MSES_EVT_DATA_AG0:   kind = MSES_K_DATA_AG0;
      default:             kind = MSES_K_NONE;
    endcase
  end

  // ---------------------------------------------------------------
  // injection starvation mode
  // ---------------------------------------------------------------
  // each class tracks how long it has failed to inject
  mses_starve_detect #(
    .CLS_N      (MSES_CLS_N),
    .STARVE_CYC (STARVE_CYC)
  ) u_starve (
    .clk_i      (CLK_I),
    .arst_n_i   (ARST_N_I),
    .blocked_i  (ING_BLOCKED_I),
    .starve_o   (starve)
  );

  // split starvation cycles by their cause
  assign prio_stv = starve & ING_PRIO_LOSS_I;
  assign crd_stv  = starve & ING_NO_CRD_I;

  // ---------------------------------------------------------------
  // condition and mask selection
  // ---------------------------------------------------------------
  // pick the raw condition vector of the selected event
  always_comb
  begin
    case (kind)
      MSES_K_OCC:      cond_vec = '1;               // occupancy gated below
      MSES_K_ALLOC:    cond_vec = ING_ALLOC_I;
      MSES_K_BYPASS:   cond_vec = ING_BYPASS_I;
      MSES_K_CRD_STV:  cond_vec = crd_stv;
      MSES_K_CRD_EXT:  cond_vec = crd_stv;
      MSES_K_PRIO_STV: cond_vec = prio_stv;
      MSES_K_HSINK:    cond_vec = HSINK_STARVE_I;
      MSES_K_VSINK:    cond_vec = VSINK_STARVE_I;
      MSES_K_ADDR_AG0: cond_vec = ADDR_AG0_STALL_I;
      MSES_K_ADDR_AG1: cond_vec = ADDR_AG1_STALL_I;
      MSES_K_DATA_AG0: cond_vec = DATA_AG0_STALL_I;
      default:         cond_vec = '0;
    endcase
  end

  // unit mask bits that the selected event honours
  always_comb
  begin
    case (kind)
      MSES_K_OCC,
      MSES_K_ALLOC,
      MSES_K_BYPASS,
      MSES_K_CRD_STV:  valid_msk = MSES_ING_MASK;
      MSES_K_CRD_EXT:  valid_msk = MSES_CRD_EXT_MSK;
      MSES_K_PRIO_STV: valid_msk = MSES_PRIO_MASK;
      MSES_K_HSINK:    valid_msk = MSES_HSINK_MASK;
      MSES_K_VSINK:    valid_msk = MSES_VSINK_MASK;
      MSES_K_ADDR_AG0,
      MSES_K_ADDR_AG1,
      MSES_K_DATA_AG0: valid_msk = MSES_XGR_MASK;
      default:         valid_msk = '0;
    endcase
  end

  // qualified classes or transgress indices
  assign ing_en  = UMASK_I & valid_msk;
  assign hit_vec = ing_en & cond_vec;
  assign any_hit = |hit_vec;

  // ---------------------------------------------------------------
  // increment amount
  // ---------------------------------------------------------------
  // occupancy adds the depth of every enabled class
  mses_occ_sum #(
    .CLS_N  (MSES_CLS_N),
    .OCC_W  (OCC_W),
    .SUM_W  (INC_W)
  ) u_occ (
    .occ_i  (ING_OCC_I),
    .en_i   (ing_en),
    .sum_o  (occ_sum)
  );

  // allocations and bypasses add one per enabled class that fired
  assign cnt_chain[0] = '0;
  genvar g;
  generate
    for (g = 0; g < MSES_CLS_N; g++)
    begin : g_cnt
      assign cnt_chain[g+1] = cnt_chain[g] + INC_W'(hit_vec[g]);
    end
  endgenerate
  assign hit_cnt = cnt_chain[MSES_CLS_N];

  // cycle events add one when any enabled condition holds
  assign is_occ  = (kind == MSES_K_OCC);
  assign is_sum  = (kind == MSES_K_ALLOC) || (kind == MSES_K_BYPASS);
  assign inc_sel = is_occ ? occ_sum :
                   is_sum ? hit_cnt :
                   INC_W'(any_hit);

  // counting only proceeds while software has it enabled
  assign inc_nxt = COUNT_EN_I ? inc_sel : '0;
  assign hit_nxt = COUNT_EN_I && (is_occ ? (occ_sum != '0) : any_hit);
  assign ok_nxt  = (kind != MSES_K_NONE);

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  // one cycle after the condition, the increment is presented
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      inc_r <= '0;
    end
    else
    begin
      inc_r <= inc_nxt;
    end
  end

  // hit flag stands in the same cycle as its increment
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      hit_r <= 1'b0;
    end
    else
    begin
      hit_r <= hit_nxt;
    end
  end

  // supported-code status, recomputed every cycle
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ok_r <= 1'b0;
    end
    else
    begin
      ok_r <= ok_nxt;
    end
  end

  // starvation mode as presented outside the block
  assign stv_out_nxt = starve;
  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      stv_out_r <= '0;
    end
    else
    begin
      stv_out_r <= stv_out_nxt;
    end
  end

  assign INC_O         = inc_r;
  assign EVT_HIT_O     = hit_r;
  assign CODE_OK_O     = ok_r;
  assign STARVE_MODE_O = stv_out_r;
endmodule
`default_nettype wire

// ---- verilog/mses_pkg.sv ----
// constants shared by the mesh stop event selection block
`default_nettype none
package mses_pkg;
  // ---------------------------------------------------------------
  // field widths
  // ---------------------------------------------------------------
  localparam int unsigned MSES_CODE_W  = 8;
  localparam int unsigned MSES_UMASK_W = 8;
  localparam int unsigned MSES_CLS_N   = 8;

  // ---------------------------------------------------------------
  // event codes
  // ---------------------------------------------------------------
  localparam logic [7:0] MSES_EVT_OCC        = 8'he0;
  localparam logic [7:0] MSES_EVT_ALLOC      = 8'he1;
  localparam logic [7:0] MSES_EVT_BYPASS     = 8'he2;
  localparam logic [7:0] MSES_EVT_CRD_STARVE = 8'he3;
  localparam logic [7:0] MSES_EVT_CRD_EXT    = 8'he4;
  localparam logic [7:0] MSES_EVT_PRIO_STV   = 8'he5;
  localparam logic [7:0] MSES_EVT_HSINK      = 8'had;
  localparam logic [7:0] MSES_EVT_VSINK      = 8'hab;
  localparam logic [7:0] MSES_EVT_ADDR_AG0   = 8'hd0;
  localparam logic [7:0] MSES_EVT_ADDR_AG1   = 8'hd2;
  localparam logic [7:0] MSES_EVT_DATA_AG0   = 8'hd4;

  // ---------------------------------------------------------------
  // ingress class bit positions in the unit mask
  // ---------------------------------------------------------------
  localparam int unsigned MSES_CLS_ADDR_UNCRD = 0;
  localparam int unsigned MSES_CLS_ACK        = 1;
  localparam int unsigned MSES_CLS_DATA_UNCRD = 2;
  localparam int unsigned MSES_CLS_INVAL      = 3;
  localparam int unsigned MSES_CLS_ADDR_CRD   = 4;
  localparam int unsigned MSES_CLS_DATA_CRD   = 6;
  localparam int unsigned MSES_CLS_ACK_CRD    = 7;

  // ---------------------------------------------------------------
  // unit mask bits each event honours
  // ---------------------------------------------------------------
  localparam logic [7:0] MSES_ING_MASK    = 8'hdf; // bits 0-4, 6, 7
  localparam logic [7:0] MSES_PRIO_MASK   = 8'h55; // addr/data both kinds
  localparam logic [7:0] MSES_CRD_EXT_MSK = 8'h80; // ack-credit only
  localparam logic [7:0] MSES_HSINK_MASK  = 8'h2f; // 0-3 and agent1 ack
  localparam logic [7:0] MSES_VSINK_MASK  = 8'h1f; // 0-3 and ack credit
  localparam logic [7:0] MSES_XGR_MASK    = 8'hff; // transgress 0..7
  localparam logic [7:0] MSES_UMASK_RST   = 8'h00;
  localparam logic [7:0] MSES_CODE_RST    = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned MSES_STARVE_CYC = 64; // blocked cycles to starve

  // ---------------------------------------------------------------
  // decoded event kinds
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MSES_K_NONE     = 4'h0,
    MSES_K_OCC      = 4'h1,
    MSES_K_ALLOC    = 4'h2,
    MSES_K_BYPASS   = 4'h3,
    MSES_K_CRD_STV  = 4'h4,
    MSES_K_CRD_EXT  = 4'h5,
    MSES_K_PRIO_STV = 4'h6,
    MSES_K_HSINK    = 4'h7,
    MSES_K_VSINK    = 4'h8,
    MSES_K_ADDR_AG0 = 4'h9,
    MSES_K_ADDR_AG1 = 4'ha,
    MSES_K_DATA_AG0 = 4'hb
  } mses_kind_t;
endpackage
`default_nettype wire

// ---- verilog/mses_starve_detect.sv ----
// per-class injection starvation detector for the ingress
`default_nettype none
module mses_starve_detect
  import mses_pkg::*;
#(
  parameter int unsigned CLS_N      = MSES_CLS_N,
  parameter int unsigned STARVE_CYC = MSES_STARVE_CYC
)(
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [CLS_N-1:0] blocked_i,
  output logic      [CLS_N-1:0] starve_o
);
  localparam int unsigned CNT_W = $clog2(STARVE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_TOP = CNT_W'(STARVE_CYC);

  // ---------------------------------------------------------------
  // one blocked-cycle counter per class
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CLS_N; g++)
    begin : g_cls
      logic [CNT_W-1:0] cnt_r;
      logic [CNT_W-1:0] cnt_nxt;
      logic             stv_r;
      logic             stv_nxt;
      // count consecutive blocked cycles, clear once traffic moves
      assign cnt_nxt = !blocked_i[g] ? '0 :
                       (cnt_r == CNT_TOP) ? cnt_r : cnt_r + CNT_W'(1);
      // enter after a prolonged stall, leave when it clears
      assign stv_nxt = blocked_i[g] && (cnt_nxt == CNT_TOP);
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          cnt_r <= '0;
          stv_r <= 1'b0;
        end
        else
        begin
          cnt_r <= cnt_nxt;
          stv_r <= stv_nxt;
        end
      end
      assign starve_o[g] = stv_r;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- verilog/mses_occ_sum.sv ----
// adds the occupancy of every enabled ingress class
`default_nettype none
module mses_occ_sum
  import mses_pkg::*;
#(
  parameter int unsigned CLS_N = MSES_CLS_N,
  parameter int unsigned OCC_W = 6,
  parameter int unsigned SUM_W = OCC_W + 3
)(
  input  wire logic [CLS_N*OCC_W-1:0] occ_i,
  input  wire logic [CLS_N-1:0]       en_i,
  output logic      [SUM_W-1:0]       sum_o
);
  // ---------------------------------------------------------------
  // gated per-class terms, summed
  // ---------------------------------------------------------------
  logic [SUM_W-1:0] term [CLS_N];
  genvar g;
  generate
    for (g = 0; g < CLS_N; g++)
    begin : g_term
      assign term[g] = en_i[g] ? SUM_W'(occ_i[g*OCC_W +: OCC_W]) : '0;
    end
  endgenerate

  // running sum of the gated terms
  always_comb
  begin
    sum_o = '0;
    for (int i = 0; i < CLS_N; i++)
    begin
      sum_o = sum_o + term[i];
    end
  end
endmodule
`default_nettype wire

// ---- verif/mses_ring_model.sv ----
// behavioural ingress queues and blocking causes on the far side
`default_nettype none
module mses_ring_model
  import mses_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  alloc_i,
  input  wire logic [7:0]  fwd_i,
  input  wire logic [7:0]  hold_i,
  input  wire logic        prio_i,
  output logic      [47:0] occ_o,
  output logic      [7:0]  blocked_o,
  output logic      [7:0]  prio_loss_o,
  output logic      [7:0]  no_crd_o
);
  logic [5:0] occ_r [8];

  // --------
  // queues
  // --------
  // entries wait until forwarded; a held class cannot forward
  always @(posedge clk_i or negedge arst_n_i)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!arst_n_i)
        occ_r[i] <= 6'h00;
      else
        occ_r[i] <= occ_r[i] + 6'(alloc_i[i])
                    - 6'(fwd_i[i] && !hold_i[i] && occ_r[i] != 6'h00);
    end
  end

  // occupancy levels and the cause of each blocked class
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      occ_o[i*6 +: 6] = occ_r[i];
  end
  assign blocked_o   = hold_i;
  assign prio_loss_o = prio_i ? hold_i : 8'h00;
  assign no_crd_o    = prio_i ? 8'h00 : hold_i;
endmodule
`default_nettype wire

// ---- verif/mses_props.sv ----
// port assertions for the mesh stop event selection block
`default_nettype none
module mses_props
  import mses_pkg::*;
#(
  parameter int unsigned OCC_W = 6,
  parameter int unsigned INC_W = OCC_W + 3
)(
  input wire logic             CLK_I,
  input wire logic             ARST_N_I,
  input wire logic [7:0]       EVT_CODE_I,
  input wire logic [7:0]       UMASK_I,
  input wire logic             COUNT_EN_I,
  input wire logic [7:0]       ING_ALLOC_I,
  input wire logic [7:0]       ING_BYPASS_I,
  input wire logic [7:0]       ING_BLOCKED_I,
  input wire logic [7:0]       HSINK_STARVE_I,
  input wire logic [7:0]       VSINK_STARVE_I,
  input wire logic [7:0]       ADDR_AG0_STALL_I,
  input wire logic [INC_W-1:0] INC_O,
  input wire logic             EVT_HIT_O,
  input wire logic             CODE_OK_O,
  input wire logic [7:0]       STARVE_MODE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  logic live_r;

  // skips the first edge after reset release
  always_ff @(posedge CLK_I or negedge ARST_N_I)
    if (!ARST_N_I)
      live_r <= 1'b0;
    else
      live_r <= 1'b1;

  // counting and code decode qualifiers
  wire logic go    = live_r && COUNT_EN_I;
  wire logic known = EVT_CODE_I inside {8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he5,
                                        8'had, 8'hab, 8'hd0, 8'hd2, 8'hd4};

  sequence s_blocked_run;
    ING_BLOCKED_I[0] [*6];
  endsequence
  sequence s_mode_on;
    ##[0:2] STARVE_MODE_O[0];
  endsequence

  a_unknown_code_zero: assert property (live_r && !known |=> INC_O == '0 && !CODE_OK_O)
    else $error("unknown code gave a count");
  a_known_code_ok: assert property (live_r && known |=> CODE_OK_O)
    else $error("supported code not flagged");
  a_count_gate: assert property (live_r && !COUNT_EN_I |=> INC_O == '0 && !EVT_HIT_O)
    else $error("count while disabled");
  a_alloc_sum: assert property (go && EVT_CODE_I == MSES_EVT_ALLOC |=>
    INC_O == $countones($past(UMASK_I & ING_ALLOC_I) & MSES_ING_MASK))
    else $error("allocation sum wrong");
  a_bypass_sum: assert property (go && EVT_CODE_I == MSES_EVT_BYPASS |=>
    INC_O == $countones($past(UMASK_I & ING_BYPASS_I) & MSES_ING_MASK))
    else $error("bypass sum wrong");
  a_xgress_any: assert property (go && EVT_CODE_I == MSES_EVT_ADDR_AG0 |=>
    INC_O == ($past(|(UMASK_I & ADDR_AG0_STALL_I)) ? 1 : 0))
    else $error("transgress stall count wrong");
  a_hsink_any: assert property (go && EVT_CODE_I == MSES_EVT_HSINK |=>
    INC_O == ($past(|(UMASK_I & HSINK_STARVE_I & MSES_HSINK_MASK)) ? 1 : 0))
    else $error("horizontal sink count wrong");
  a_vsink_any: assert property (go && EVT_CODE_I == MSES_EVT_VSINK |=>
    INC_O == ($past(|(UMASK_I & VSINK_STARVE_I & MSES_VSINK_MASK)) ? 1 : 0))
    else $error("vertical sink count wrong");
  a_hit_matches_inc: assert property (EVT_HIT_O == (INC_O != '0))
    else $error("hit flag disagrees with increment");
  a_starve_entry: assert property (s_blocked_run |-> s_mode_on)
    else $error("starvation mode not entered");
  a_starve_exit: assert property (!ING_BLOCKED_I[0] |-> ##3 !STARVE_MODE_O[0])
    else $error("starvation mode without blocking");
endmodule

bind mses_top mses_props #(.OCC_W(OCC_W), .INC_W(INC_W)) props (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .EVT_CODE_I(EVT_CODE_I), .UMASK_I(UMASK_I),
  .COUNT_EN_I(COUNT_EN_I), .ING_ALLOC_I(ING_ALLOC_I), .ING_BYPASS_I(ING_BYPASS_I),
  .ING_BLOCKED_I(ING_BLOCKED_I), .HSINK_STARVE_I(HSINK_STARVE_I),
  .VSINK_STARVE_I(VSINK_STARVE_I), .ADDR_AG0_STALL_I(ADDR_AG0_STALL_I), .INC_O(INC_O),
  .EVT_HIT_O(EVT_HIT_O), .CODE_OK_O(CODE_OK_O), .STARVE_MODE_O(STARVE_MODE_O));
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the mesh stop event selection block
`default_nettype none
module tb
  import mses_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, arst_n = 1'b0, en = 1'b0, prio = 1'b0;
  logic [7:0] code = 8'h00, mask = 8'h00, v = 8'h00, alloc = 8'h00;
  logic [7:0] hold = 8'h00, fwd = 8'h00;
  logic [7:0] ms [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h11, 8'h44, 8'h20, 8'h80, 8'hff};
  logic [7:0] xc [3] = '{MSES_EVT_ADDR_AG0, MSES_EVT_ADDR_AG1, MSES_EVT_DATA_AG0};
  wire logic [47:0] occ;
  wire logic [7:0]  blk, pl, nc, st;
  wire logic [8:0]  inc;
  wire logic        hit, ok;
  int mismatches = 0, samples_checked = 0, cycles = 0;

  // the selected source sees v, the other bypass, sink and stall sources its inverse
  mses_top #(.STARVE_CYC(4)) uut (
    .CLK_I(clk), .ARST_N_I(arst_n), .EVT_CODE_I(code), .UMASK_I(mask), .COUNT_EN_I(en),
    .ING_ALLOC_I(alloc), .ING_BYPASS_I(code == MSES_EVT_BYPASS ? v : ~v), .ING_OCC_I(occ),
    .ING_BLOCKED_I(blk), .ING_PRIO_LOSS_I(pl), .ING_NO_CRD_I(nc),
    .HSINK_STARVE_I(code == MSES_EVT_HSINK ? v : ~v),
    .VSINK_STARVE_I(code == MSES_EVT_VSINK ? v : ~v),
    .ADDR_AG0_STALL_I(code == xc[0] ? v : ~v), .ADDR_AG1_STALL_I(code == xc[1] ? v : ~v),
    .DATA_AG0_STALL_I(code == xc[2] ? v : ~v),
    .INC_O(inc), .EVT_HIT_O(hit), .CODE_OK_O(ok), .STARVE_MODE_O(st));
  mses_ring_model far (
    .clk_i(clk), .arst_n_i(arst_n), .alloc_i(alloc), .fwd_i(fwd), .hold_i(hold),
    .prio_i(prio), .occ_o(occ), .blocked_o(blk), .prio_loss_o(pl), .no_crd_o(nc));

  // clock and hang guard
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // --------
  // tasks
  // --------
  task automatic check(input string name, input logic [8:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // program while stopped, enable counting and leave it on, compare the first cycle's increment and hit
  task automatic run(input logic [7:0] c, m, d, input logic [8:0] exp);
    @(negedge clk);
    en = 1'b0; code = c; mask = m; v = 8'h00;
    @(negedge clk);
    en = 1'b1; v = d; alloc = (c == MSES_EVT_ALLOC) ? d : 8'h00;
    @(negedge clk);
    check("increment", inc, exp);
    check("hit", {8'h00, hit}, {8'h00, exp != 9'h000});
    v = 8'h00; alloc = 8'h00;
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // --------
  // tests
  // --------
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    check("mode", {1'b0, st}, 9'h000);
    foreach (ms[i])
    begin
      run(MSES_EVT_ALLOC, ms[i], 8'hff, 9'($countones(ms[i] & 8'hdf)));
      run(MSES_EVT_BYPASS, ms[i], 8'hff, 9'($countones(ms[i] & 8'hdf)));
    end
    run(MSES_EVT_OCC, 8'h11, 8'h00, 9'd20);
    run(MSES_EVT_OCC, 8'hff, 8'h00, 9'd70);
    run(MSES_EVT_OCC, 8'h20, 8'h00, 9'd0);
    $display("ingress count test done");
    foreach (xc[j])
    begin
      for (int n = 0; n < 8; n++)
      begin
        run(xc[j], 8'h01 << n, 8'h01 << n, 9'h001);
        run(xc[j], 8'h01 << n, ~(8'h01 << n), 9'h000);
      end
    end
    run(MSES_EVT_HSINK, 8'h20, 8'h20, 9'h001);
    run(MSES_EVT_HSINK, 8'h10, 8'h10, 9'h000);
    run(MSES_EVT_VSINK, 8'h10, 8'h10, 9'h001);
    run(MSES_EVT_VSINK, 8'h20, 8'h20, 9'h000);
    check("code ok", {8'h00, ok}, 9'h001);
    run(8'he6, 8'hff, 8'hff, 9'h000);
    check("code ok", {8'h00, ok}, 9'h000);
    @(negedge clk);
    en = 1'b0; code = MSES_EVT_ALLOC; alloc = 8'hff;
    @(negedge clk);
    check("stopped", inc, 9'h000);
    alloc = 8'h00;
    $display("selection test done");
    run(MSES_EVT_PRIO_STV, 8'h11, 8'h00, 9'h000);
    hold = 8'h91; prio = 1'b1; fwd = 8'hff;
    repeat (2) @(negedge clk);
    check("early", inc, 9'h000);
    for (int i = 0; i < 10 && st !== 8'h91; i++) @(negedge clk);
    check("mode", {1'b0, st}, 9'h091);
    check("busy", inc, 9'h001);
    run(MSES_EVT_PRIO_STV, 8'h80, 8'h00, 9'h000);
    prio = 1'b0;
    run(MSES_EVT_PRIO_STV, 8'h11, 8'h00, 9'h000);
    run(MSES_EVT_CRD_STARVE, 8'h01, 8'h00, 9'h001);
    run(MSES_EVT_CRD_STARVE, 8'h80, 8'h00, 9'h001);
    run(MSES_EVT_CRD_EXT, 8'h80, 8'h00, 9'h001);
    run(MSES_EVT_CRD_EXT, 8'h01, 8'h00, 9'h000);
    run(MSES_EVT_OCC, 8'hff, 8'h00, 9'd33);
    arst_n = 1'b0;
    @(negedge clk);
    check("mode in reset", {1'b0, st}, 9'h000);
    arst_n = 1'b1;
    hold = 8'h00;
    repeat (4) @(negedge clk);
    check("mode off", {1'b0, st}, 9'h000);
    $display("starvation test done");
    end_sim();
  end
endmodule
`default_nettype wire
